// ### core/ser_pkg.sv
package ser_pkg;

	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 32;

	// Register offsets, one aligned word each
	localparam logic [7:0]  OFF_ESR       = 8'h00;
	localparam logic [7:0]  OFF_ESE       = 8'h04;
	localparam logic [7:0]  OFF_SRE       = 8'h08;
	localparam logic [7:0]  OFF_STB       = 8'h0C;
	localparam logic [7:0]  OFF_EVQ       = 8'h10;
	localparam logic [7:0]  OFF_EVQ_CNT   = 8'h14;
	localparam logic [7:0]  OFF_IRQ_STAT  = 8'h18;
	localparam logic [7:0]  OFF_IRQ_MASK  = 8'h1C;

	// Event status bit positions
	localparam int          ESR_OPC       = 0;
	localparam int          ESR_QYE       = 2;
	localparam int          ESR_DDE       = 3;
	localparam int          ESR_EXE       = 4;
	localparam int          ESR_CME       = 5;
	localparam int          ESR_PON       = 7;
	localparam logic [7:0]  ESR_M_OPC     = 8'h01 << ESR_OPC;
	localparam logic [7:0]  ESR_M_QYE     = 8'h01 << ESR_QYE;
	localparam logic [7:0]  ESR_M_DDE     = 8'h01 << ESR_DDE;
	localparam logic [7:0]  ESR_M_EXE     = 8'h01 << ESR_EXE;
	localparam logic [7:0]  ESR_M_CME     = 8'h01 << ESR_CME;
	localparam logic [7:0]  ESR_RST       = 8'h01 << ESR_PON;

	// Status byte bit positions
	localparam int          STB_EAV       = 2;
	localparam int          STB_MAV       = 4;
	localparam int          STB_ESB       = 5;
	localparam int          STB_MSS       = 6;
	localparam logic [7:0]  STB_M_MSS     = 8'h01 << STB_MSS;

	localparam logic [31:0] MASK_MAX      = 32'h000000FF;

	// Event queue
	localparam int          EVQ_DEPTH     = 10;
	localparam int          PTR_W         = 4;
	localparam logic [3:0]  EVQ_LAST      = 4'h9;
	localparam logic [3:0]  EVQ_FULL      = 4'hA;

	// Interrupt status bits
	localparam int          IRQ_W         = 3;
	localparam int          IRQ_SRQ       = 0;
	localparam int          IRQ_OVF       = 1;
	localparam int          IRQ_NEW       = 2;

	localparam logic [7:0]  BOARD_ADDR    = 8'h00;
	localparam logic [7:0]  SLOT_BASE     = 8'h01;

	// Error codes, two's complement
	localparam logic [15:0] CODE_SYNTAX   = 16'hFF9A;
	localparam logic [15:0] CODE_BAD_CHAR = 16'hFF87;
	localparam logic [15:0] CODE_EXP_BIG  = 16'hFF85;
	localparam logic [15:0] CODE_EXEC     = 16'hFF38;
	localparam logic [15:0] CODE_TRIG_IGN = 16'hFF2D;
	localparam logic [15:0] CODE_INIT_IGN = 16'hFF2B;
	localparam logic [15:0] CODE_RANGE    = 16'hFF22;
	localparam logic [15:0] CODE_TOO_MUCH = 16'hFF21;
	localparam logic [15:0] CODE_SHIFT_HW = 16'hFF10;
	localparam logic [15:0] CODE_UNK_MOD  = 16'hFF0F;
	localparam logic [15:0] CODE_QOVF     = 16'hFEA2;

	typedef enum logic [3:0] {
		ERR_SYNTAX, ERR_BAD_CHAR, ERR_EXP_BIG, ERR_EXEC_RSVD,
		ERR_TRIG_IGN, ERR_INIT_IGN, ERR_RANGE, ERR_TOO_MUCH,
		ERR_SHIFT_VFY, ERR_UNK_MOD, ERR_QUEUE_OVF
	} ser_err_t;

	typedef struct packed {
		logic [15:0] code;
		logic [7:0]  maddr;
	} ser_entry_t;

	typedef struct packed {
		logic        valid;
		ser_err_t    id;
		logic [3:0]  slot;
	} ser_err_req_t;

	typedef struct packed {
		logic [7:0]       esr;
		logic [7:0]       ese;
		logic [7:0]       sre;
		logic             mav;
		logic             rej_pend;
		logic [PTR_W-1:0] wptr;
		logic [PTR_W-1:0] rptr;
		logic [PTR_W-1:0] cnt;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic             srq_prev;
		logic [31:0]      rd_data;
		logic             evq_sel;
	} ser_state_t;

	localparam ser_state_t SER_RST = '{esr: ESR_RST, default: '0};

	function automatic logic [15:0] err_code(input ser_err_t e);
		case (e)
			ERR_SYNTAX:    err_code = CODE_SYNTAX;
			ERR_BAD_CHAR:  err_code = CODE_BAD_CHAR;
			ERR_EXP_BIG:   err_code = CODE_EXP_BIG;
			ERR_EXEC_RSVD: err_code = CODE_EXEC;
			ERR_TRIG_IGN:  err_code = CODE_TRIG_IGN;
			ERR_INIT_IGN:  err_code = CODE_INIT_IGN;
			ERR_RANGE:     err_code = CODE_RANGE;
			ERR_TOO_MUCH:  err_code = CODE_TOO_MUCH;
			ERR_SHIFT_VFY: err_code = CODE_SHIFT_HW;
			ERR_UNK_MOD:   err_code = CODE_UNK_MOD;
			ERR_QUEUE_OVF: err_code = CODE_QOVF;
			default:       err_code = CODE_EXEC;
		endcase
	endfunction

	function automatic logic [7:0] err_bit(input ser_err_t e);
		case (e)
			ERR_SYNTAX, ERR_BAD_CHAR, ERR_EXP_BIG:
				err_bit = ESR_M_CME;
			ERR_QUEUE_OVF:
				err_bit = ESR_M_DDE;
			default:
				err_bit = ESR_M_EXE;
		endcase
	endfunction

endpackage

// ### core/ser_evq_mem.sv
`timescale 1ns/1ps
module ser_evq_mem (
	input  wire logic                      core_clk,
	input  wire logic                      ce,
	input  wire logic                      we,
	input  wire logic [ser_pkg::PTR_W-1:0] waddr,
	input  wire ser_pkg::ser_entry_t       wdata,
	input  wire logic [ser_pkg::PTR_W-1:0] raddr,
	output ser_pkg::ser_entry_t            rdata
);
	import ser_pkg::*;

	// No reset on the array; the pointers guard stale slots
	ser_entry_t mem [EVQ_DEPTH];

	always_ff @(posedge core_clk) begin
		if (ce) begin
			if (we) begin
				mem[waddr] <= wdata;
			end
			rdata <= mem[raddr];
		end
	end

endmodule

// ### core/ser_core.sv
`timescale 1ns/1ps
// Contract
// - An error input sets its event status bit and appends a queue entry (overflow entry over the newest when full); opc_done and query_err set bits only.
// - Event summary bit is set when any status bit is enabled by mask.
// - Placing output into the output queue sets message-available.
// - Enabled status byte bit sets master summary and raises service request.
// - Parse errors carry negative command codes and set event bit 5.
// - Execution errors carry execution codes and set event bit 4.
// - Queue overflow is a device error with its code, sets bit 3.
// - Event enable and request mask loads above 255 are rejected and logged as out of range.
// - Module address is one for carrier slot, plus one per slot right.
// - Buffer and list overflows report the too-much-data code.
// - Shift readback failure and unknown module have distinct hardware codes.
// - Reading event status returns the bits, then clears them all.
// - Event queue holds ten entries first-in first-out, reads remove.
// - Request mask bit 4 enables message-available, bit 5 event summary.
module ser_core (
	input  wire logic                       core_clk,
	input  wire logic                       rst_n,
	input  wire logic                       ce,
	input  wire logic [ser_pkg::ADDR_W-1:0] bus_addr,
	input  wire logic [ser_pkg::DATA_W-1:0] bus_wdata,
	input  wire logic                       bus_wr,
	input  wire logic                       bus_rd,
	output logic      [ser_pkg::DATA_W-1:0] bus_rdata,
	input  wire ser_pkg::ser_err_req_t      err_in,
	output logic                            err_ready,
	input  wire logic                       opc_done,
	input  wire logic                       query_err,
	input  wire logic                       oq_put,
	input  wire logic                       oq_empty,
	output logic      [7:0]                 status_byte,
	output logic                            srq,
	output logic                            irq
);
	import ser_pkg::*;

	ser_state_t           s_q;
	ser_state_t           s_d;
	ser_entry_t           mem_rdata;
	ser_entry_t           mem_wdata;
	ser_entry_t           new_ent;
	logic [PTR_W-1:0]     mem_waddr;
	logic                 mem_we;
	logic                 acc;
	logic                 push;
	logic                 pop;
	logic                 full;
	logic                 rd_clr;
	logic [7:0]           esr_set;
	logic [7:0]           acc_mask;
	logic [IRQ_W-1:0]     irq_set;
	logic [IRQ_W-1:0]     irq_clr;
	logic [7:0]           stb_w;
	logic                 srq_w;

	function automatic logic reg_hit(input logic [7:0] a,
		input logic [7:0] off);
		reg_hit = (a == off);
	endfunction

	function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
		ptr_inc = (p == EVQ_LAST) ? '0 : PTR_W'(p + 1'b1);
	endfunction

	function automatic logic [PTR_W-1:0] ptr_dec(input logic [PTR_W-1:0] p);
		ptr_dec = (p == '0) ? EVQ_LAST : PTR_W'(p - 1'b1);
	endfunction

	// Status byte without its master summary bit
	always_comb begin
		stb_w = 8'h00;
		stb_w[STB_EAV] = (s_q.cnt != '0);
		stb_w[STB_MAV] = s_q.mav;
		stb_w[STB_ESB] = |(s_q.esr & s_q.ese);
	end

	// Bit 6 of the request mask cannot feed back into itself
	assign srq_w = |(stb_w & s_q.sre & ~STB_M_MSS);
	assign srq = srq_w;
	assign status_byte = stb_w | (srq_w ? STB_M_MSS : 8'h00);
	assign irq = |(s_q.irq_stat & s_q.irq_mask);

	// A pending mask reject takes the queue port for one cycle
	assign err_ready = !s_q.rej_pend;
	assign acc = err_in.valid && err_ready;
	assign push = s_q.rej_pend || acc;
	assign pop = bus_rd && reg_hit(bus_addr, OFF_EVQ) &&
		(s_q.cnt != '0);
	// A pop in the same cycle frees a slot, so no overflow then
	assign full = (s_q.cnt == EVQ_FULL) && !pop;
	assign rd_clr = bus_rd && reg_hit(bus_addr, OFF_ESR);
	assign acc_mask = acc ? err_bit(err_in.id) : 8'h00;
	assign irq_clr = (bus_wr && reg_hit(bus_addr, OFF_IRQ_STAT)) ?
		bus_wdata[IRQ_W-1:0] : '0;

	always_comb begin
		new_ent.code = CODE_RANGE;
		new_ent.maddr = BOARD_ADDR;
		if (!s_q.rej_pend) begin
			new_ent.code = err_code(err_in.id);
			new_ent.maddr = SLOT_BASE + {4'h0, err_in.slot};
		end
	end

	always_comb begin
		s_d = s_q;
		s_d.rej_pend = 1'b0;
		esr_set = 8'h00;
		irq_set = '0;
		mem_we = 1'b0;
		mem_waddr = s_q.wptr;
		mem_wdata = new_ent;

		if (push) begin
			mem_we = 1'b1;
			irq_set[IRQ_NEW] = 1'b1;
			esr_set = s_q.rej_pend ? ESR_M_EXE : err_bit(err_in.id);
			if (full) begin
				// Oldest entries survive; newest marks the loss
				mem_waddr = ptr_dec(s_q.wptr);
				mem_wdata.code = CODE_QOVF;
				mem_wdata.maddr = BOARD_ADDR;
				esr_set = esr_set | ESR_M_DDE;
				irq_set[IRQ_OVF] = 1'b1;
			end else begin
				s_d.wptr = ptr_inc(s_q.wptr);
			end
		end

		if (pop) begin
			s_d.rptr = ptr_inc(s_q.rptr);
		end
		case ({push && !full, pop})
			2'b10: s_d.cnt = PTR_W'(s_q.cnt + 1'b1);
			2'b01: s_d.cnt = PTR_W'(s_q.cnt - 1'b1);
			default: s_d.cnt = s_q.cnt;
		endcase

		if (opc_done) begin
			esr_set = esr_set | ESR_M_OPC;
		end
		if (query_err) begin
			esr_set = esr_set | ESR_M_QYE;
		end
		// New events win over the clear of a read
		s_d.esr = (rd_clr ? 8'h00 : s_q.esr) | esr_set;

		s_d.mav = oq_put || (s_q.mav && !oq_empty);

		irq_set[IRQ_SRQ] = srq_w && !s_q.srq_prev;
		s_d.srq_prev = srq_w;
		s_d.irq_stat = (s_q.irq_stat & ~irq_clr) | irq_set;

		if (bus_wr) begin
			case (bus_addr)
				OFF_ESE: begin
					if (bus_wdata > MASK_MAX) begin
						s_d.rej_pend = 1'b1;
					end else begin
						s_d.ese = bus_wdata[7:0];
					end
				end
				OFF_SRE: begin
					if (bus_wdata > MASK_MAX) begin
						s_d.rej_pend = 1'b1;
					end else begin
						s_d.sre = bus_wdata[7:0];
					end
				end
				OFF_IRQ_MASK: begin
					s_d.irq_mask = bus_wdata[IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end

		s_d.rd_data = 32'h00000000;
		s_d.evq_sel = 1'b0;
		if (bus_rd) begin
			case (bus_addr)
				OFF_ESR:      s_d.rd_data = {24'h000000, s_q.esr};
				OFF_ESE:      s_d.rd_data = {24'h000000, s_q.ese};
				OFF_SRE:      s_d.rd_data = {24'h000000, s_q.sre};
				OFF_STB:      s_d.rd_data = {24'h000000, status_byte};
				OFF_EVQ:      s_d.evq_sel = (s_q.cnt != '0);
				OFF_EVQ_CNT:  s_d.rd_data = {28'h0000000, s_q.cnt};
				OFF_IRQ_STAT: s_d.rd_data = {29'h00000000, s_q.irq_stat};
				OFF_IRQ_MASK: s_d.rd_data = {29'h00000000, s_q.irq_mask};
				default:      s_d.rd_data = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= SER_RST;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	// Entry data come straight from the memory's output register
	assign bus_rdata = s_q.evq_sel ? {1'b1, 7'h00, mem_rdata} :
		s_q.rd_data;

	ser_evq_mem u_evq (
		.core_clk (core_clk),
		.ce       (ce),
		.we       (mem_we),
		.waddr    (mem_waddr),
		.wdata    (mem_wdata),
		.raddr    (s_q.rptr),
		.rdata    (mem_rdata)
	);

	default clocking cb @(posedge core_clk iff ce);
	endclocking
	default disable iff (!rst_n);

	a_esr_event_set: assert property (
		acc |=> ((s_q.esr & $past(acc_mask)) == $past(acc_mask)))
		else $error("accepted event did not set its status bit");

	a_queue_append: assert property (
		(push && !full && !pop) |=> (s_q.cnt == $past(s_q.cnt) + 4'h1))
		else $error("event not appended to queue");

	a_esb_summary: assert property (
		((s_q.esr & s_q.ese) != 8'h00) |-> status_byte[STB_ESB])
		else $error("event summary bit missing");

	a_mav_on_put: assert property (
		oq_put |=> status_byte[STB_MAV])
		else $error("message available not set after output");

	// Worked from the sources, not from the summary net it guards
	a_srq_raise: assert property (
		((s_q.sre[STB_MAV] && s_q.mav) ||
		(s_q.sre[STB_ESB] && ((s_q.esr & s_q.ese) != 8'h00)) ||
		(s_q.sre[STB_EAV] && (s_q.cnt != '0))) |->
		(srq && status_byte[STB_MSS]))
		else $error("service request not raised");

	a_mss_follows: assert property (
		status_byte[STB_MSS] == srq)
		else $error("master summary differs from request");

	a_srq_quiet: assert property (
		((stb_w & s_q.sre & ~STB_M_MSS) == 8'h00) |-> !srq)
		else $error("spurious service request");

	a_cmd_bit5: assert property (
		(acc && err_in.id inside {ERR_SYNTAX, ERR_BAD_CHAR, ERR_EXP_BIG})
		|=> s_q.esr[ESR_CME])
		else $error("command error did not set bit 5");

	a_exe_bit4: assert property (
		(acc && err_in.id inside {ERR_EXEC_RSVD, ERR_TRIG_IGN,
		ERR_INIT_IGN, ERR_RANGE}) |=> s_q.esr[ESR_EXE])
		else $error("execution error did not set bit 4");

	a_ovf_bit3: assert property (
		(acc && err_in.id == ERR_QUEUE_OVF) |=> s_q.esr[ESR_DDE])
		else $error("queue overflow did not set bit 3");

	a_mask_reject: assert property (
		(bus_wr && reg_hit(bus_addr, OFF_ESE) && bus_wdata > MASK_MAX)
		|=> ($stable(s_q.ese) && s_q.rej_pend) ##1 s_q.esr[ESR_EXE])
		else $error("oversized mask load not rejected");

	a_mod_address: assert property (
		(mem_we && !s_q.rej_pend && !full) |->
		(mem_wdata.maddr == SLOT_BASE + {4'h0, err_in.slot}))
		else $error("wrong module address in entry");

	a_esr_clear: assert property (
		(rd_clr && esr_set == 8'h00) |=> (s_q.esr == 8'h00))
		else $error("event status not cleared by read");

	a_queue_bound: assert property (
		s_q.cnt <= EVQ_FULL)
		else $error("event queue count above depth");

	a_pop_remove: assert property (
		(pop && !(push && !full)) |=> (s_q.cnt == $past(s_q.cnt) - 4'h1))
		else $error("read entry not removed from queue");

	// The reject entry must own the queue port for its cycle
	a_reject_stall: assert property (
		(bus_wr && (bus_wdata > MASK_MAX) &&
		(reg_hit(bus_addr, OFF_ESE) || reg_hit(bus_addr, OFF_SRE)))
		|=> !err_ready)
		else $error("error port not held during reject entry");

	a_ovf_marks_dde: assert property (
		(push && full) |=> s_q.esr[ESR_DDE])
		else $error("queue overflow did not set bit 3");

	a_full_keep: assert property (
		(push && full) |-> (mem_wdata.code == CODE_QOVF) ##1
		(s_q.cnt == EVQ_FULL))
		else $error("full queue not marked with overflow entry");

endmodule

// ### verif/ser_err_src.sv
`timescale 1ns/1ps
module ser_err_src (
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	input  wire logic              go,
	input  wire ser_pkg::ser_err_t id,
	input  wire logic [3:0]        slot,
	input  wire logic              err_ready,
	output ser_pkg::ser_err_req_t  err_in
);
	import ser_pkg::*;
	// Held until taken; released fields flipped so stale data never matches
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			err_in <= '0;
		end else if (err_in.valid && err_ready) begin
			err_in <= '{1'b0, ser_err_t'(~err_in.id), ~err_in.slot};
		end else if (go) begin
			err_in <= '{1'b1, id, slot};
		end
	end
endmodule

// ### verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import ser_pkg::*;
	logic              core_clk    = 1'b0;
	logic              rst_n       = 1'b0;
	logic              ce          = 1'b1;
	logic [ADDR_W-1:0] bus_addr    = '0;
	logic [DATA_W-1:0] bus_wdata   = '0;
	logic              bus_wr      = 1'b0;
	logic              bus_rd      = 1'b0;
	logic [DATA_W-1:0] bus_rdata;
	ser_err_req_t      err_in;
	logic              err_ready;
	logic              opc_done    = 1'b0;
	logic              query_err   = 1'b0;
	logic              oq_put      = 1'b0;
	logic              oq_empty    = 1'b1;
	logic [7:0]        status_byte;
	logic              srq;
	logic              irq;
	logic              go          = 1'b0;
	ser_err_t          go_id       = ERR_SYNTAX;
	logic [3:0]        go_slot     = 4'h0;
	logic              rd_seen     = 1'b0;
	logic [31:0]       exp_q[$];
	logic [15:0]       codes[11];
	logic [7:0]        bits[11];
	logic [3:0]        slot;
	int                error_cnt   = 0;
	int                checks_done = 0;
	int                cycles      = 0;
	int                seed        = 32'h9AF593EA;

	always #2 core_clk = ~core_clk;

	ser_core ser_core_i (.core_clk(core_clk), .rst_n(rst_n), .ce(ce),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_rdata(bus_rdata), .err_in(err_in),
		.err_ready(err_ready), .opc_done(opc_done), .query_err(query_err),
		.oq_put(oq_put), .oq_empty(oq_empty), .status_byte(status_byte),
		.srq(srq), .irq(irq));
	ser_err_src ser_err_src_i (.core_clk(core_clk), .rst_n(rst_n), .go(go),
		.id(go_id), .slot(go_slot), .err_ready(err_ready), .err_in(err_in));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic test_end(input int n);
		$display("test %0d done, checks %0d", n, checks_done);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		bus_addr  <= a;
		bus_wdata <= d;
		bus_wr    <= 1'b1;
		@(posedge core_clk);
		bus_wr    <= 1'b0;
	endtask

	// Expectation noted first; the monitor pops it when data stands
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		@(posedge core_clk);
		bus_addr <= a;
		bus_rd   <= 1'b1;
		@(posedge core_clk);
		bus_rd   <= 1'b0;
	endtask

	task automatic pulse(input int w);
		@(posedge core_clk);
		if (w == 0)
			opc_done <= 1'b1;
		else if (w == 1)
			query_err <= 1'b1;
		else
			oq_put <= 1'b1;
		@(posedge core_clk);
		{opc_done, query_err, oq_put} <= 3'b000;
		@(negedge core_clk);
	endtask

	task automatic err(input ser_err_t id, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge core_clk);
		go      <= 1'b1;
		go_id   <= id;
		go_slot <= s;
		@(posedge core_clk);
		go      <= 1'b0;
		@(negedge core_clk);
		while (err_in.valid !== 1'b0 && n < 8) begin
			n++;
			@(negedge core_clk);
		end
	endtask

	always @(posedge core_clk) rd_seen <= bus_rd;

	always @(negedge core_clk) begin
		if (rd_seen) begin
			chk(bus_rdata, exp_q.pop_front());
		end
	end

	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			error_cnt++;
			complete_run();
		end
	end

	initial begin
		codes = '{CODE_SYNTAX, CODE_BAD_CHAR, CODE_EXP_BIG, CODE_EXEC,
			CODE_TRIG_IGN, CODE_INIT_IGN, CODE_RANGE, CODE_TOO_MUCH,
			CODE_SHIFT_HW, CODE_UNK_MOD, CODE_QOVF};
		bits = '{8'h20, 8'h20, 8'h20, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10,
			8'h10, 8'h10, 8'h08};
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(OFF_ESR, 32'h80);
		rd(OFF_ESR, 32'h0);
		pulse(0);
		pulse(1);
		rd(OFF_ESR, 32'h5);
		test_end(1);
		for (int i = 0; i < 11; i++) begin
			slot = 4'($random(seed));
			err(ser_err_t'(i), slot);
			rd(OFF_ESR, {24'h0, bits[i]});
			rd(OFF_EVQ, {8'h80, codes[i], 4'h0, slot} + 32'h1);
		end
		rd(OFF_EVQ_CNT, 32'h0);
		rd(OFF_EVQ, 32'h0);
		test_end(2);
		wr(OFF_ESE, 32'h20);
		wr(OFF_SRE, 32'h20);
		wr(OFF_IRQ_MASK, 32'h1);
		err(ERR_SYNTAX, 4'h0);
		chk({24'h0, status_byte & 8'h74}, 32'h64);
		chk({31'h0, srq}, 32'h1);
		@(negedge core_clk);
		chk({31'h0, irq}, 32'h1);
		wr(OFF_IRQ_MASK, 32'h0);
		@(negedge core_clk);
		chk({31'h0, irq}, 32'h0);
		wr(OFF_IRQ_MASK, 32'h1);
		wr(OFF_IRQ_STAT, 32'h7);
		@(negedge core_clk);
		chk({31'h0, irq}, 32'h0);
		rd(OFF_EVQ, 32'h80FF9A01);
		rd(OFF_ESR, 32'h20);
		@(negedge core_clk);
		chk({24'h0, status_byte}, 32'h0);
		chk({31'h0, srq}, 32'h0);
		test_end(3);
		wr(OFF_SRE, 32'h10);
		oq_empty <= 1'b0;
		pulse(2);
		chk({24'h0, status_byte}, 32'h50);
		chk({31'h0, srq}, 32'h1);
		@(posedge core_clk);
		oq_empty <= 1'b1;
		@(posedge core_clk);
		@(negedge core_clk);
		chk({24'h0, status_byte}, 32'h0);
		test_end(4);
		wr(OFF_ESE, 32'h100);
		@(negedge core_clk);
		chk({31'h0, err_ready}, 32'h0);
		wr(OFF_SRE, 32'h1FF);
		rd(OFF_ESE, 32'h20);
		rd(OFF_SRE, 32'h10);
		@(negedge core_clk);
		chk({31'h0, err_ready}, 32'h1);
		rd(OFF_ESR, 32'h10);
		rd(OFF_EVQ, 32'h80FF2200);
		rd(OFF_EVQ, 32'h80FF2200);
		rd(8'h22, 32'h0);
		test_end(5);
		wr(OFF_SRE, 32'h0);
		wr(OFF_IRQ_STAT, 32'h7);
		for (int i = 0; i < 12; i++) begin
			err(ERR_RANGE, 4'(i));
		end
		chk({31'h0, status_byte[2]}, 32'h1);
		rd(OFF_EVQ_CNT, 32'hA);
		rd(OFF_IRQ_STAT, 32'h6);
		rd(OFF_ESR, 32'h18);
		for (int i = 0; i < 9; i++) begin
			rd(OFF_EVQ, 32'h80FF2201 + i);
		end
		rd(OFF_EVQ, 32'h80FEA200);
		rd(OFF_EVQ, 32'h0);
		test_end(6);
		repeat (4) @(posedge core_clk);
		complete_run();
	end
endmodule
